// ---- core/prc_map.svh ----
// Purpose: Constants for the receive PTP message classifier
// Assumes: Byte offsets count from the first byte of the frame or message
// Notes: Included by the core module only; the package does not include it
`ifndef PRC_MAP_SVH
`define PRC_MAP_SVH

`define PRC_ETYPE_OFS 16'h000C
`define PRC_VLAN_TPID 16'h8100
`define PRC_IPV4_ETYPE 16'h0800
`define PRC_IPV6_ETYPE 16'h86DD
`define PRC_UDP_PROTO 8'h11
`define PRC_UDP_EVENT_PORT 16'h013F
`define PRC_UDP_GENERAL_PORT 16'h0140
`define PRC_V6_HDR_LEN 16'h0028
`define PRC_UDP_HDR_LEN 16'h0008
`define PRC_MSG_ID_OFS 16'h0000
`define PRC_MSG_VER_OFS 16'h0001
`define PRC_SRC_PORT_OFS 16'h001C
`define PRC_SEQ_OFS 16'h001E
`define PRC_CTRL_OFS 16'h0020
`define PRC_V2_VERSION 4'h2
`define PRC_V2_PDELAY_REQ 4'h2
`define PRC_V2_PDELAY_RESP 4'h3
`define PRC_L2_CLASS 4'hE

`endif

// ---- core/prc_pkg.sv ----
// Purpose: Types for the receive PTP message classifier
// Assumes: Constants come from prc_map.svh
// Notes: One-hot parser states
package prc_pkg;

    typedef enum logic [5:0] {
        PRC_IDLE = 6'h01,
        PRC_HDR = 6'h02,
        PRC_MSG = 6'h04,
        PRC_SKIP = 6'h08,
        PRC_END = 6'h10,
        PRC_LOCK = 6'h20
    } prc_state_t;

    typedef struct packed {
        prc_state_t state;
        logic [15:0] pos;
        logic [15:0] etype;
        logic [15:0] l3_base;
        logic [15:0] msg_base;
        logic is_v6;
        logic is_l2;
        logic is_udp_ip;
        logic [7:0] ip_proto;
        logic [15:0] dport;
        logic is_v2;
        logic [7:0] byte0;
        logic [7:0] ctrl;
        logic got_ctrl;
        logic [15:0] src_port;
        logic [15:0] seq;
        logic got_seq;
        logic [63:0] ts_hold;
        logic locked;
        logic [63:0] cap_time;
        logic [15:0] cap_src_port;
        logic [15:0] seq_number;
        logic capture_done_flag;
        logic [3:0] rx_frame_class_field;
        logic desc_valid;
    } prc_regs_t;

endpackage : prc_pkg

// ---- core/prc_classifier.sv ----
// Purpose: Parse received frames, classify PTP messages and latch a timestamp
// Assumes: One byte per cycle with start and last marks, synchronous to clk
// Notes: Timestamp regs stay locked until sw_ack; descriptor bits pulse at frame end
// What this block does
// - Version 1 messages accepted only as UDP over IPv4, never layer 2.
// - Version 2 accepted over layer 2 Ethertype, or UDP over IPv4 or IPv6.
// - Layer 2 path: Ethernet header, optional VLAN tag skipped, PTP Ethertype, message.
// - After recognising PTP by Ethertype or port, determine version before decoding.
// - Version 1 compares control byte at offset 32 with configured value.
// - Version 2 compares message identifier at offset 0 with configured value.
// - Version 1 codes 0 to 4 defined; 5 to 255 reserved, never match.
// - Version 2 codes 0-3 event, 8-D general; 4-7 and E-F unused.
// - In version 2 mode always timestamp peer-delay request and response.
// - Source port at offsets 28-29, sequence at 30-31, both versions.
// - On match latch time, source port, sequence; flag timestamp taken.
// - Latched values stay locked until software access; later matches ignored.
// - UDP PTP recognised by destination port 319 or 320.
// - Layer 2 PTP frames get frame class 0xE even without timestamp.
`include "prc_map.svh"
`timescale 1ns/100ps

module prc_classifier
    import prc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic rx_valid,
    input wire logic rx_sof,
    input wire logic rx_eof,
    input wire logic [7:0] rx_data,
    input wire logic [63:0] sys_time,
    input wire logic [15:0] cfg_ptp_etype,
    input wire logic cfg_v2_mode,
    input wire logic [7:0] cfg_msg_type,
    input wire logic sw_ack,
    output logic ts_locked,
    output logic [63:0] cap_time,
    output logic [15:0] cap_src_port,
    output logic [15:0] seq_number,
    output logic desc_valid,
    output logic capture_done_flag,
    output logic [3:0] rx_frame_class_field
);

    prc_regs_t r;
    prc_regs_t n;
    logic [15:0] rel;
    logic is_ptp;
    logic v1_ok;
    logic v2_ok;
    logic type_hit;
    logic pdelay;

    // Combinational next-state of the whole parser
    always_comb begin
        n = r;
        n.desc_valid = 1'b0;
        n.capture_done_flag = 1'b0;
        n.rx_frame_class_field = 4'h0;
        rel = r.pos - r.msg_base;
        is_ptp = 1'b0;
        v1_ok = 1'b0;
        v2_ok = 1'b0;
        type_hit = 1'b0;
        pdelay = 1'b0;
        if (sw_ack) begin
            n.locked = 1'b0;
        end
        if (rx_valid) begin
            if (rx_sof) begin
                // Restart on every start mark so a truncated frame cannot leak state
                n.state = PRC_HDR;
                n.pos = 16'h0001;
                n.etype = 16'h0000;
                n.l3_base = 16'h000E;
                n.msg_base = 16'hFFFF;
                n.is_v6 = 1'b0;
                n.is_l2 = 1'b0;
                n.is_udp_ip = 1'b0;
                n.ip_proto = 8'h00;
                n.dport = 16'h0000;
                n.is_v2 = 1'b0;
                n.got_ctrl = 1'b0;
                n.got_seq = 1'b0;
                // Time of the first byte is the capture point
                n.ts_hold = sys_time;
            end else if (r.state != PRC_IDLE) begin
                n.pos = r.pos + 16'h0001;
                if (r.pos == r.l3_base - 16'h0002) begin
                    n.etype[15:8] = rx_data;
                end
                if (r.pos == r.l3_base - 16'h0001) begin
                    n.etype[7:0] = rx_data;
                    if ({r.etype[15:8], rx_data} == `PRC_VLAN_TPID) begin
                        n.l3_base = r.l3_base + 16'h0004;
                    end else if ({r.etype[15:8], rx_data} == cfg_ptp_etype) begin
                        n.is_l2 = 1'b1;
                        n.msg_base = r.pos + 16'h0001;
                    end else if ({r.etype[15:8], rx_data} == `PRC_IPV6_ETYPE) begin
                        n.is_v6 = 1'b1;
                    end else if ({r.etype[15:8], rx_data} != `PRC_IPV4_ETYPE) begin
                        n.state = PRC_SKIP;
                    end
                end
                // IP header: protocol and header length find the UDP header
                if (r.etype == `PRC_IPV4_ETYPE && !r.is_v6) begin
                    if (r.pos == r.l3_base) begin
                        n.msg_base = r.l3_base + {10'h000, rx_data[3:0], 2'h0} + `PRC_UDP_HDR_LEN;
                    end
                    if (r.pos == r.l3_base + 16'h0009) begin
                        n.ip_proto = rx_data;
                    end
                end
                if (r.is_v6) begin
                    if (r.pos == r.l3_base) begin
                        n.msg_base = r.l3_base + `PRC_V6_HDR_LEN + `PRC_UDP_HDR_LEN;
                    end
                    if (r.pos == r.l3_base + 16'h0006) begin
                        n.ip_proto = rx_data;
                    end
                end
                if (!r.is_l2 && r.pos == r.msg_base - 16'h0006) begin
                    n.dport[15:8] = rx_data;
                end
                if (!r.is_l2 && r.pos == r.msg_base - 16'h0005) begin
                    n.dport[7:0] = rx_data;
                    n.is_udp_ip = (r.ip_proto == `PRC_UDP_PROTO)
                        && ({r.dport[15:8], rx_data} == `PRC_UDP_EVENT_PORT
                        || {r.dport[15:8], rx_data} == `PRC_UDP_GENERAL_PORT);
                end
                // Message fields, by offset from message start
                if (r.pos >= r.msg_base) begin
                    if (rel == `PRC_MSG_ID_OFS) begin
                        n.byte0 = rx_data;
                    end
                    if (rel == `PRC_MSG_VER_OFS) begin
                        n.is_v2 = (rx_data[3:0] == `PRC_V2_VERSION);
                    end
                    if (rel == `PRC_SRC_PORT_OFS) begin
                        n.src_port[15:8] = rx_data;
                    end
                    if (rel == `PRC_SRC_PORT_OFS + 16'h0001) begin
                        n.src_port[7:0] = rx_data;
                    end
                    if (rel == `PRC_SEQ_OFS) begin
                        n.seq[15:8] = rx_data;
                    end
                    if (rel == `PRC_SEQ_OFS + 16'h0001) begin
                        n.seq[7:0] = rx_data;
                        n.got_seq = 1'b1;
                    end
                    if (rel == `PRC_CTRL_OFS) begin
                        n.ctrl = rx_data;
                        n.got_ctrl = 1'b1;
                    end
                end
            end
            // Frame end: classify and decide on capture
            if (rx_eof && (r.state != PRC_IDLE || rx_sof)) begin
                n.state = PRC_IDLE;
                n.desc_valid = 1'b1;
                is_ptp = n.is_l2 || n.is_udp_ip;
                // version 1 only over UDP IPv4
                v1_ok = !n.is_v2 && n.is_udp_ip && !n.is_v6 && n.got_ctrl;
                // version 2 over L2 or UDP
                v2_ok = n.is_v2 && n.got_seq;
                // reserved codes never equal a defined type
                if (v1_ok) begin
                    type_hit = (n.ctrl == cfg_msg_type) && (n.ctrl <= 8'h04);
                end
                if (v2_ok) begin
                    type_hit = (n.byte0[3:0] == cfg_msg_type[3:0])
                        && (n.byte0[3:0] <= 4'h3 || (n.byte0[3:0] >= 4'h8 && n.byte0[3:0] <= 4'hD));
                    pdelay = cfg_v2_mode
                        && (n.byte0[3:0] == `PRC_V2_PDELAY_REQ || n.byte0[3:0] == `PRC_V2_PDELAY_RESP);
                end
                if (n.is_l2) begin
                    n.rx_frame_class_field = `PRC_L2_CLASS;
                end
                if (is_ptp && (v1_ok || v2_ok) && (type_hit || pdelay) && !r.locked) begin
                    n.cap_time = r.ts_hold;
                    n.cap_src_port = n.src_port;
                    n.seq_number = n.seq;
                    n.capture_done_flag = 1'b1;
                    n.locked = 1'b1;
                end
            end
        end
    end

    // Single register stage for all state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
            r.state <= PRC_IDLE;
            r.msg_base <= 16'hFFFF;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from flops
    assign ts_locked = r.locked;
    assign cap_time = r.cap_time;
    assign cap_src_port = r.cap_src_port;
    assign seq_number = r.seq_number;
    assign desc_valid = r.desc_valid;
    assign capture_done_flag = r.capture_done_flag;
    assign rx_frame_class_field = r.rx_frame_class_field;

endmodule : prc_classifier

// ---- bench/prc_chk.sv ----
// Purpose: Port-level checks on the PTP receive classifier
// Assumes: Only the ports of prc_classifier are visible
// Notes: Bound at the foot of this file
`timescale 1ns/100ps
module prc_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic rx_valid,
    input wire logic rx_eof,
    input wire logic sw_ack,
    input wire logic ts_locked,
    input wire logic [63:0] cap_time,
    input wire logic desc_valid,
    input wire logic capture_done_flag,
    input wire logic [3:0] rx_frame_class_field
);
    // One domain, so one clock and one reset for all checks
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    desc_after_eof_a: assert property (rx_valid && rx_eof |=> desc_valid)
        else $error("descriptor pulse missing after last byte");
    desc_cause_a: assert property (desc_valid |-> $past(rx_valid && rx_eof))
        else $error("descriptor pulse without a last byte");
    flag_with_desc_a: assert property (capture_done_flag |-> desc_valid && ts_locked)
        else $error("capture flag outside descriptor or unlocked");
    no_recapture_a: assert property (capture_done_flag |-> !$past(ts_locked) || $past(sw_ack))
        else $error("capture taken while locked");
    time_held_a: assert property ($past(ts_locked) && !capture_done_flag |-> $stable(cap_time))
        else $error("captured time moved while locked");
    ack_unlocks_a: assert property (sw_ack && !(rx_valid && rx_eof) |=> !ts_locked)
        else $error("lock survived software access");
    lock_cause_a: assert property ($rose(ts_locked) |-> capture_done_flag)
        else $error("lock rose without capture");
    class_code_a: assert property (rx_frame_class_field != 4'h0 |-> desc_valid && rx_frame_class_field == 4'hE)
        else $error("bad frame class");
    cover property (capture_done_flag);
    cover property (desc_valid && !capture_done_flag && rx_frame_class_field == 4'hE);
    cover property (sw_ack && ts_locked);
endmodule : prc_chk

bind prc_classifier prc_chk u_chk (.clk, .nrst, .rx_valid, .rx_eof, .sw_ack, .ts_locked, .cap_time,
    .desc_valid, .capture_done_flag, .rx_frame_class_field);

// ---- bench/prc_mac_model.sv ----
// Purpose: MAC receive path feeding frame bytes
// Assumes: The bench fills frame before calling send
// Notes: Random stalls inside frames; idle data never repeats the last byte
`timescale 1ns/100ps
module prc_mac_model (
    input wire logic clk,
    output logic rx_valid,
    output logic rx_sof,
    output logic rx_eof,
    output logic [7:0] rx_data
);
    logic [7:0] frame [0:127];
    int seed = 91852;
    // Quiet line at time zero
    initial begin
        rx_valid = 1'b0;
        rx_sof = 1'b0;
        rx_eof = 1'b0;
        rx_data = 8'h00;
    end
    // One byte per strobe, with junk shown during stalls
    task automatic send(input int len);
        int i;
        for (i = 0; i < len; i++) begin
            @(negedge clk);
            while ($random(seed) % 5 == 0) begin
                rx_valid = 1'b0;
                rx_sof = 1'b0;
                rx_eof = 1'b0;
                rx_data = $random(seed);
                @(negedge clk);
            end
            rx_valid = 1'b1;
            rx_sof = i == 0;
            rx_eof = i == len - 1;
            rx_data = frame[i];
        end
        @(negedge clk);
        rx_valid = 1'b0;
        rx_sof = 1'b0;
        rx_eof = 1'b0;
        rx_data = ~rx_data;
    endtask : send
endmodule : prc_mac_model

// ---- bench/prc_classifier_test.sv ----
// Purpose: Self-checking run of the PTP receive classifier
// Assumes: Frames come from prc_mac_model, inputs change at falling edges
// Notes: Expected results queue at send time and are popped per descriptor
`timescale 1ns/100ps
module prc_classifier_test;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic rx_valid, rx_sof, rx_eof, ts_locked, desc_valid, capture_done_flag;
    logic [7:0] rx_data;
    logic [63:0] sys_time = 64'h0;
    logic [63:0] sof_t, cap_time;
    logic cfg_v2_mode = 1'b0;
    logic [7:0] cfg_msg_type = 8'h00;
    logic sw_ack = 1'b0;
    logic lk = 1'b0;
    logic [3:0] rx_frame_class_field;
    logic [15:0] cap_src_port, seq_number;
    logic [31:0] r;
    logic [36:0] e;
    logic [36:0] exp_q[$];
    int seed = 91852;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    int i;
    // Clock at 250 MHz
    initial begin
        forever #2 clk = ~clk;
    end
    prc_mac_model u_mac (.clk, .rx_valid, .rx_sof, .rx_eof, .rx_data);
    prc_classifier u_dut (.clk, .nrst, .rx_valid, .rx_sof, .rx_eof, .rx_data, .sys_time,
        .cfg_ptp_etype(16'h88F7), .cfg_v2_mode, .cfg_msg_type, .sw_ack, .ts_locked, .cap_time,
        .cap_src_port, .seq_number, .desc_valid, .capture_done_flag, .rx_frame_class_field);
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task tally_and_finish;
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    // Software access pulse; lock falls whatever the DUT held
    task ack;
        @(negedge clk);
        sw_ack = 1'b1;
        @(negedge clk);
        sw_ack = 1'b0;
        lk = 1'b0;
    endtask : ack
    // Kind k: 0 L2, 1 L2 with tag, 2 UDP IPv4, 3 UDP IPv6; ml message bytes
    task automatic frm(input int k, input int v, input logic [7:0] c, input int ml, input logic [15:0] pt);
        int b;
        int j;
        logic m;
        b = k == 0 ? 14 : k == 1 ? 18 : k == 2 ? 42 : 62;
        for (j = 0; j < 128; j++) u_mac.frame[j] = $random(seed);
        {u_mac.frame[12], u_mac.frame[13]} = k == 2 ? 16'h0800 : k == 3 ? 16'h86DD : k == 1 ? 16'h8100 : 16'h88F7;
        {u_mac.frame[16], u_mac.frame[17]} = 16'h88F7;
        u_mac.frame[14] = k == 3 ? 8'h60 : 8'h45;
        u_mac.frame[k == 3 ? 20 : 23] = 8'h11;
        if (k > 1) {u_mac.frame[b - 6], u_mac.frame[b - 5]} = pt;
        if (v == 2) u_mac.frame[b] = c;
        u_mac.frame[b + 1][3:0] = v == 2 ? 4'h2 : 4'h1;
        u_mac.frame[b + 32] = c;
        m = (k < 2 || pt == 16'h013F || pt == 16'h0140) && ml > (v == 2 ? 31 : 32)
            && (v == 2 ? (c[3:0] inside {[4'h0:4'h3], [4'h8:4'hD]}) && c[3:0] == cfg_msg_type[3:0]
            || cfg_v2_mode && c[3:1] == 3'h1 : k == 2 && c == cfg_msg_type && c < 8'h05);
        m = m && !lk;
        lk = lk | m;
        exp_q.push_back({m, k < 2 ? 4'hE : 4'h0, u_mac.frame[b + 28], u_mac.frame[b + 29],
            u_mac.frame[b + 30], u_mac.frame[b + 31]});
        u_mac.send(b + ml);
    endtask : frm
    // Note the time of each first byte at the edge where the DUT takes it
    always @(posedge clk) begin
        if (rx_valid && rx_sof) sof_t <= sys_time;
    end
    // Watch descriptors at the falling edge, where registered outputs have settled
    always @(negedge clk) begin
        cyc <= cyc + 1;
        if (desc_valid === 1'b1) begin
            e = exp_q.pop_front();
            chk(64'({capture_done_flag, rx_frame_class_field}), 64'(e[36:32]));
            if (e[36]) chk(64'({cap_src_port, seq_number}), 64'(e[31:0]));
            if (e[36]) chk(cap_time, sof_t);
        end
        if (cyc == 30000) begin
            failures++;
            tally_and_finish;
        end
    end
    always @(negedge clk) sys_time <= sys_time + 64'h3;
    initial begin
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        for (i = 0; i < 32; i++) begin
            r = $random(seed);
            cfg_v2_mode = i[4];
            cfg_msg_type = i[0] ? {r[7:4], 4'(i)} : r[7:0];
            frm(i % 2, 2, 8'(i % 16), 44, 16'h0000);
            ack;
        end
        // v1 control codes over UDP IPv4
        for (i = 0; i < 8; i++) begin
            r = $random(seed);
            cfg_msg_type = i[0] ? 8'(i) : r[7:0];
            frm(2, 1, 8'(i), 44, i[1] ? 16'h013F : 16'h0140);
            ack;
        end
        // transports, lock, short and stray frames
        cfg_msg_type = 8'h00;
        frm(0, 1, 8'h00, 44, 16'h0000);
        frm(3, 1, 8'h00, 44, 16'h013F);
        frm(3, 2, 8'h00, 44, 16'h013F);
        frm(1, 2, 8'h00, 44, 16'h0000);
        ack;
        frm(0, 2, 8'h00, 31, 16'h0000);
        frm(2, 1, 8'h00, 32, 16'h0140);
        frm(2, 2, 8'h00, 44, 16'h0141);
        frm(2, 2, 8'h00, 44, 16'h0140);
        repeat (4) @(negedge clk);
        chk(64'(exp_q.size()), 64'h0);
        tally_and_finish;
    end
endmodule : prc_classifier_test
